// ---- design/micaw_regs.vh ----
// Constants for the indexed control access and wakeup interrupt unit.
// Assumes the includer uses them as plain sized literals.
`ifndef MICAW_REGS_VH
`define MICAW_REGS_VH

// Selector register
`define MICAW_SEL_W        5
`define MICAW_SEL_RESET    5'h1f
`define MICAW_SEL_WR_BIT   4
// Selector codes, low four bits
`define MICAW_C_CAP_LO     4'h0
`define MICAW_C_CAP_HI     4'h1
`define MICAW_C_CMP2_LO    4'h2
`define MICAW_C_CMP2_HI    4'h3
`define MICAW_C_CMP1_LO    4'h4
`define MICAW_C_CMP1_HI    4'h5
`define MICAW_C_CTL_B      4'h6
`define MICAW_C_CTL_A      4'h7
`define MICAW_C_COMPARATOR 4'h8
`define MICAW_C_WK_PEND    4'h9
`define MICAW_C_WK_EDGE    4'ha
`define MICAW_C_WK_MASK    4'hb
// Full selector codes
`define MICAW_SEL_TMR_CLR  5'h10
// Port indices
`define MICAW_PORT_A       3'h0
`define MICAW_PORT_B       3'h1
`define MICAW_PORT_C       3'h2
`define MICAW_NUM_PORTS    5
// Port config register select (selector bits 1:0 for codes xC..xF)
`define MICAW_CFG_SCHMITT  2'h0
`define MICAW_CFG_LEVEL    2'h1
`define MICAW_CFG_PULLUP   2'h2
`define MICAW_CFG_DIR      2'h3
// Reset values
`define MICAW_CFG_RESET    8'hff
`define MICAW_WK_RESET     8'hff
`define MICAW_ZERO8        8'h00
// Timer control B pending flag positions
`define MICAW_CTLB_REALTIME_COUNTER    0
`define MICAW_CTLB_CMP     1
`define MICAW_CTLB_CAP     2
`define MICAW_CTLB_OVF     3
// Timer control A enable positions for the three timer sources
`define MICAW_CTLA_CMP_EN  1
`define MICAW_CTLA_CAP_EN  2
`define MICAW_CTLA_OVF_EN  3

`endif

// ---- design/micaw_port_cfg.v ----
// One port's four configuration registers: schmitt, level, pullup, direction.
// Assumes write strobes and data are synchronous to clk.
`default_nettype none
`include "micaw_regs.vh"

module micaw_port_cfg #(
	parameter HAS_SCHMITT = 1
) (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Access
	input  wire       wr_en,
	input  wire [1:0] reg_sel,
	input  wire [7:0] wdata,
	output reg  [7:0] rdata,
	// Register contents
	output reg  [7:0] dir_q,
	output reg  [7:0] level_q,
	output reg  [7:0] pullup_off_q,
	output reg  [7:0] schmitt_off_q
);

	// Register writes, all ones after reset
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_q         <= `MICAW_CFG_RESET;
			level_q       <= `MICAW_CFG_RESET;
			pullup_off_q  <= `MICAW_CFG_RESET;
			schmitt_off_q <= `MICAW_CFG_RESET;
		end
		else if (wr_en)
		begin
			case (reg_sel)
				`MICAW_CFG_DIR:    dir_q        <= wdata;
				`MICAW_CFG_LEVEL:  level_q      <= wdata;
				`MICAW_CFG_PULLUP: pullup_off_q <= wdata;
				default:           if (HAS_SCHMITT != 0) schmitt_off_q <= wdata;
			endcase
		end
	end

	// Read mux
	always @*
	begin
		case (reg_sel)
			`MICAW_CFG_DIR:    rdata = dir_q;
			`MICAW_CFG_LEVEL:  rdata = level_q;
			`MICAW_CFG_PULLUP: rdata = pullup_off_q;
			default:           rdata = (HAS_SCHMITT != 0) ? schmitt_off_q : `MICAW_ZERO8;
		endcase
	end

endmodule // micaw_port_cfg
`default_nettype wire

// ---- design/micaw_wake_edge.v ----
// Per-pin edge detector for the eight wakeup/interrupt pins.
// Assumes pins are synchronous to clk; edges are ignored until one sample is held.
`default_nettype none
`include "micaw_regs.vh"

module micaw_wake_edge (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Pins and edge choice
	input  wire [7:0] pin,
	input  wire [7:0] falling_sel,
	// One-cycle edge flags
	output wire [7:0] edge_hit
);

	reg  [7:0] prev_q;
	reg        armed_q;

	// Previous sample and arming after reset
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_q  <= `MICAW_ZERO8;
			armed_q <= 1'b0;
		end
		else
		begin
			prev_q  <= pin;
			armed_q <= 1'b1;
		end
	end

	// Edge compare per pin
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_pin
			assign edge_hit[i] = armed_q & (falling_sel[i] ? (prev_q[i] & ~pin[i]) : (~prev_q[i] & pin[i]));
		end
	endgenerate

endmodule // micaw_wake_edge
`default_nettype wire

// ---- design/micaw_ctrl_access.v ----
// Indexed access to hidden port and timer control registers, plus wakeup edge interrupts.
// Assumes the CPU core gives one-cycle strobes synchronous to core_clk, at most one per cycle.
`default_nettype none
`include "micaw_regs.vh"

module micaw_ctrl_access (
	// Clock and reset
	input  wire        core_clk,
	input  wire        resetn,
	// Selector instructions from the core
	input  wire        sel_lit_stb,
	input  wire [3:0]  sel_lit,
	input  wire        sel_w_stb,
	input  wire        sel_rd_stb,
	// Port control move from the core
	input  wire        ctl_move_stb,
	input  wire [2:0]  ctl_port,
	input  wire [7:0]  w_in,
	// Answer to the working register
	output reg         w_load,
	output reg  [7:0]  w_out,
	// Port configuration, five ports of eight bits, port A lowest
	output wire [39:0] port_dir,
	output wire [39:0] port_level_ttl,
	output wire [39:0] port_pullup_off,
	output wire [39:0] port_schmitt_off,
	// Comparator control
	output reg  [7:0]  comparator_control,
	// Timer registers, timer 1 in the low half
	input  wire [31:0] tmr_capture,
	input  wire [1:0]  tmr_ovf_evt,
	input  wire [1:0]  tmr_cmp_evt,
	input  wire [1:0]  tmr_cap_evt,
	output wire [31:0] tmr_compare1,
	output wire [31:0] tmr_compare2,
	output wire [15:0] tmr_control_a,
	output wire [15:0] tmr_control_b,
	output reg  [1:0]  tmr_clear,
	// Realtime counter interrupt
	input  wire        realtime_counter_rollover,
	input  wire        realtime_counter_irq_en,
	// Wakeup pins and interrupt
	input  wire [7:0]  wake_pin,
	input  wire        power_down,
	output reg  [7:0]  wakeup_pending,
	output reg         irq_req
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release
	////////////////////////////////////////////////////////////////////////////

	reg        rst_meta_q;
	reg        rst_n_q;

	// Two-stage release of the asynchronous reset
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Selector register
	////////////////////////////////////////////////////////////////////////////

	reg  [4:0] sel_q;
	wire       sel_wr = sel_q[`MICAW_SEL_WR_BIT];
	wire [3:0] code   = sel_q[3:0];

	// Selector loads; otherwise it holds
	always @(posedge core_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			sel_q <= `MICAW_SEL_RESET;
		else if (sel_w_stb)
			sel_q <= w_in[4:0];
		else if (sel_lit_stb)
			sel_q <= {sel_q[4], sel_lit};
	end

	////////////////////////////////////////////////////////////////////////////
	// Move decode
	////////////////////////////////////////////////////////////////////////////

	wire port_b     = (ctl_port == `MICAW_PORT_B);
	wire tmr_port   = port_b | (ctl_port == `MICAW_PORT_C);
	wire tmr_idx    = ~port_b;
	wire cfg_code   = (code[3:2] == 2'h3);
	wire port_valid = (ctl_port < `MICAW_NUM_PORTS);
	wire cfg_ok     = port_valid & ~(code[1:0] == `MICAW_CFG_SCHMITT && ctl_port == `MICAW_PORT_A);

	// exchange on comparator and pending codes
	wire xchg_cmp   = ctl_move_stb & port_b & (code == `MICAW_C_COMPARATOR);
	wire xchg_pend  = ctl_move_stb & port_b & (code == `MICAW_C_WK_PEND);
	// forced writes of edge select and mask
	wire wr_edge    = ctl_move_stb & port_b & (code == `MICAW_C_WK_EDGE);
	wire wr_mask    = ctl_move_stb & port_b & (code == `MICAW_C_WK_MASK);
	wire cfg_move   = ctl_move_stb & cfg_code & cfg_ok;
	wire cfg_wr     = cfg_move & sel_wr;
	// timer access; 10h clears, 12h..17h write, 00h..07h read
	wire tmr_move   = ctl_move_stb & tmr_port & ~code[3];
	wire tmr_rd     = tmr_move & ~sel_wr;
	wire tmr_clr    = tmr_move & (sel_q == `MICAW_SEL_TMR_CLR);
	wire tmr_wr     = tmr_move & sel_wr & (code[2:1] != 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// Port configuration registers
	////////////////////////////////////////////////////////////////////////////

	wire [39:0] cfg_rdata;

	// One register group per port; port A has no schmitt control
	genvar p;
	generate
		for (p = 0; p < `MICAW_NUM_PORTS; p = p + 1)
		begin : g_port
			micaw_port_cfg #(
				.HAS_SCHMITT (p != 0)
			) u_cfg (
				.clk           (core_clk),
				.rst_n         (rst_n_q),
				.wr_en         (cfg_wr && (ctl_port == p)),
				.reg_sel       (code[1:0]),
				.wdata         (w_in),
				.rdata         (cfg_rdata[p*8 +: 8]),
				// direction 0 output, level 1 TTL
				.dir_q         (port_dir[p*8 +: 8]),
				.level_q       (port_level_ttl[p*8 +: 8]),
				// a set bit disconnects the pullup
				.pullup_off_q  (port_pullup_off[p*8 +: 8]),
				.schmitt_off_q (port_schmitt_off[p*8 +: 8])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Timer compare and control registers
	////////////////////////////////////////////////////////////////////////////

	wire [15:0] tmr_rdata;

	genvar t;
	generate
		for (t = 0; t < 2; t = t + 1)
		begin : g_tmr
			reg  [15:0] cmp1_q;
			reg  [15:0] cmp2_q;
			reg  [7:0]  ctla_q;
			reg  [7:0]  ctlb_q;
			reg  [7:0]  evt;
			reg  [7:0]  rd;
			wire        hit = (tmr_idx == t);

			// three timer sources, rollover on timer 1 only
			always @*
			begin
				evt = `MICAW_ZERO8;
				evt[`MICAW_CTLB_OVF] = tmr_ovf_evt[t];
				evt[`MICAW_CTLB_CMP] = tmr_cmp_evt[t];
				evt[`MICAW_CTLB_CAP] = tmr_cap_evt[t];
				evt[`MICAW_CTLB_REALTIME_COUNTER] = (t == 0) & realtime_counter_rollover;
			end

			// Writes from the core; events win over a clearing write
			always @(posedge core_clk or negedge rst_n_q)
			begin
				if (!rst_n_q)
				begin
					cmp1_q <= 16'h0000;
					cmp2_q <= 16'h0000;
					ctla_q <= `MICAW_ZERO8;
					ctlb_q <= `MICAW_ZERO8;
				end
				else
				begin
					if (tmr_wr && hit && code[2:0] == 3'h2) cmp2_q[7:0]  <= w_in;
					if (tmr_wr && hit && code[2:0] == 3'h3) cmp2_q[15:8] <= w_in;
					if (tmr_wr && hit && code[2:0] == 3'h4) cmp1_q[7:0]  <= w_in;
					if (tmr_wr && hit && code[2:0] == 3'h5) cmp1_q[15:8] <= w_in;
					if (tmr_wr && hit && code[2:0] == 3'h7) ctla_q       <= w_in;
					if (tmr_wr && hit && code[2:0] == 3'h6)
						ctlb_q <= w_in | evt;
					else
						ctlb_q <= ctlb_q | evt;
				end
			end

			always @*
			begin
				case (code[2:0])
					3'h0:    rd = tmr_capture[t*16 +: 8];
					3'h1:    rd = tmr_capture[t*16+8 +: 8];
					3'h2:    rd = cmp2_q[7:0];
					3'h3:    rd = cmp2_q[15:8];
					3'h4:    rd = cmp1_q[7:0];
					3'h5:    rd = cmp1_q[15:8];
					3'h6:    rd = ctlb_q;
					default: rd = ctla_q;
				endcase
			end

			assign tmr_rdata[t*8 +: 8]     = rd;
			assign tmr_compare1[t*16 +: 16] = cmp1_q;
			assign tmr_compare2[t*16 +: 16] = cmp2_q;
			assign tmr_control_a[t*8 +: 8]  = ctla_q;
			assign tmr_control_b[t*8 +: 8]  = ctlb_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Wakeup edge interrupt registers
	////////////////////////////////////////////////////////////////////////////

	reg  [7:0] wake_edge_sel_q;
	reg  [7:0] wake_mask_q;
	wire [7:0] wake_hit;

	// edge choice per pin, shared detector
	micaw_wake_edge u_wake (
		.clk         (core_clk),
		.rst_n       (rst_n_q),
		.pin         (wake_pin),
		.falling_sel (wake_edge_sel_q),
		.edge_hit    (wake_hit)
	);

	// Edge select and mask, written only by forced writes
	always @(posedge core_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			wake_edge_sel_q <= `MICAW_WK_RESET;
			wake_mask_q     <= `MICAW_WK_RESET;
		end
		else
		begin
			if (wr_edge)
				wake_edge_sel_q <= w_in;
			if (wr_mask)
				wake_mask_q <= w_in;
		end
	end

	// Pending flags; a new edge wins over the exchange value
	always @(posedge core_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			// value after reset is not relied on
			wakeup_pending <= `MICAW_ZERO8;
		else if (xchg_pend)
			// store new value, keep fresh edges
			wakeup_pending <= w_in | wake_hit;
		else
			wakeup_pending <= wakeup_pending | wake_hit;
	end

	// Comparator control, reached by exchange only
	always @(posedge core_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			comparator_control <= `MICAW_ZERO8;
		else if (xchg_cmp)
			comparator_control <= w_in;
	end

	////////////////////////////////////////////////////////////////////////////
	// Answer to the working register
	////////////////////////////////////////////////////////////////////////////

	reg        ans_vld;
	reg  [7:0] ans_data;

	// Select the value returned by a move or selector read
	always @*
	begin
		ans_vld  = 1'b0;
		ans_data = `MICAW_ZERO8;
		if (sel_rd_stb)
		begin
			ans_vld  = 1'b1;
			ans_data = {3'h0, sel_q};
		end
		else if (xchg_cmp)
		begin
			ans_vld  = 1'b1;
			ans_data = comparator_control;
		end
		else if (xchg_pend)
		begin
			ans_vld  = 1'b1;
			ans_data = wakeup_pending;
		end
		else if (cfg_move && !sel_wr)
		begin
			ans_vld  = 1'b1;
			ans_data = cfg_rdata[ctl_port*8 +: 8];
		end
		else if (tmr_rd)
		begin
			ans_vld  = 1'b1;
			ans_data = tmr_rdata[tmr_idx*8 +: 8];
		end
	end

	// Registered answer, one cycle after the strobe
	always @(posedge core_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			w_load <= 1'b0;
			w_out  <= `MICAW_ZERO8;
		end
		else
		begin
			w_load <= ans_vld;
			if (ans_vld)
				w_out <= ans_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer clear and interrupt request
	////////////////////////////////////////////////////////////////////////////

	reg        tmr_irq;
	reg        realtime_counter_irq;
	reg        wake_irq;

	// Sources gated by their enables
	always @*
	begin
		// timer sources enabled in control A
		tmr_irq = (g_tmr[0].ctlb_q[`MICAW_CTLB_CMP] & g_tmr[0].ctla_q[`MICAW_CTLA_CMP_EN])
		        | (g_tmr[0].ctlb_q[`MICAW_CTLB_CAP] & g_tmr[0].ctla_q[`MICAW_CTLA_CAP_EN])
		        | (g_tmr[0].ctlb_q[`MICAW_CTLB_OVF] & g_tmr[0].ctla_q[`MICAW_CTLA_OVF_EN])
		        | (g_tmr[1].ctlb_q[`MICAW_CTLB_CMP] & g_tmr[1].ctla_q[`MICAW_CTLA_CMP_EN])
		        | (g_tmr[1].ctlb_q[`MICAW_CTLB_CAP] & g_tmr[1].ctla_q[`MICAW_CTLA_CAP_EN])
		        | (g_tmr[1].ctlb_q[`MICAW_CTLB_OVF] & g_tmr[1].ctla_q[`MICAW_CTLA_OVF_EN]);
		realtime_counter_irq = g_tmr[0].ctlb_q[`MICAW_CTLB_REALTIME_COUNTER] & realtime_counter_irq_en;
		// clear mask bit enables, off in power down
		wake_irq = (|(wakeup_pending & ~wake_mask_q)) & ~power_down;
	end

	// Registered request and clear pulses
	always @(posedge core_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			irq_req   <= 1'b0;
			tmr_clear <= 2'h0;
		end
		else
		begin
			irq_req   <= tmr_irq | realtime_counter_irq | wake_irq;
			tmr_clear <= {tmr_clr & tmr_idx, tmr_clr & ~tmr_idx};
		end
	end

endmodule // micaw_ctrl_access
`default_nettype wire

// ---- tb/micaw_ctrl_asserts.sv ----
// Checker on the top ports of the indexed control access unit.
// Assumes one strobe per cycle and answers registered at the taking edge.
`default_nettype none
module micaw_chk (
	// Clock and reset
	input wire logic	core_clk,
	input wire logic	resetn,
	// Core strobes
	input wire logic	sel_rd_stb,
	input wire logic	ctl_move_stb,
	input wire logic [2:0]	ctl_port,
	// Answers and state
	input wire logic	w_load,
	input wire logic [7:0]	w_out,
	input wire logic [39:0]	port_dir,
	input wire logic [7:0]	comparator_control,
	input wire logic [15:0]	tmr_control_b,
	input wire logic [1:0]	tmr_clear,
	input wire logic [1:0]	tmr_ovf_evt,
	input wire logic	realtime_counter_rollover,
	input wire logic [7:0]	wakeup_pending,
	input wire logic	irq_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Selector readback answers zero-extended
	chk_sel_answer: assert property (sel_rd_stb |=> w_load && w_out[7:5] == 3'h0)
		else $error("selector read gave no answer");
	// Rollover sets the pending flag
	chk_realtime_counter_flag: assert property (realtime_counter_rollover |=> tmr_control_b[0])
		else $error("rollover flag not set");
	// Timer 2 overflow sets its flag
	chk_ovf_flag: assert property (tmr_ovf_evt[1] |=> tmr_control_b[11])
		else $error("overflow flag not set");
	// Comparator changes only by a move
	chk_cmp_hold: assert property (!ctl_move_stb |=> $stable(comparator_control))
		else $error("comparator changed without move");
	// Direction changes only by a move
	chk_dir_hold: assert property (!ctl_move_stb |=> $stable(port_dir))
		else $error("direction changed without move");
	// Timer 2 clear pulse only from a move on port C
	chk_clear_src: assert property (tmr_clear[1] |-> $past(ctl_move_stb) && $past(ctl_port) == 3'h2)
		else $error("timer 2 clear without cause");
	// Pending bits only drop through a move
	chk_pend_keep: assert property (!ctl_move_stb |=> (wakeup_pending & $past(wakeup_pending)) == $past(wakeup_pending))
		else $error("pending bit lost");
	// Request needs a pending source
	chk_irq_cause: assert property (irq_req |-> $past(wakeup_pending) != 8'h00 || $past(tmr_control_b) != 16'h0000)
		else $error("request without pending flag");

	// Main scenarios
	cover property (sel_rd_stb ##1 w_load);
	cover property (irq_req);
	cover property (tmr_clear[1]);
endmodule // micaw_chk

bind micaw_ctrl_access micaw_chk u_chk (.core_clk(core_clk), .resetn(resetn), .sel_rd_stb(sel_rd_stb),
	.ctl_move_stb(ctl_move_stb), .ctl_port(ctl_port), .w_load(w_load), .w_out(w_out), .port_dir(port_dir),
	.comparator_control(comparator_control), .tmr_control_b(tmr_control_b), .tmr_clear(tmr_clear),
	.tmr_ovf_evt(tmr_ovf_evt), .realtime_counter_rollover(realtime_counter_rollover), .wakeup_pending(wakeup_pending),
	.irq_req(irq_req));
`default_nettype wire

// ---- tb/micaw_cpu_model.sv ----
// CPU core model issuing selector instructions and port control moves.
// Assumes the unit answers within two cycles of the taking edge.
`default_nettype none
module micaw_cpu_model (
	// Clock
	input wire logic	core_clk,
	// Strobes to the unit
	output var logic	sel_lit_stb,
	output var logic [3:0]	sel_lit,
	output var logic	sel_w_stb,
	output var logic	sel_rd_stb,
	output var logic	ctl_move_stb,
	output var logic [2:0]	ctl_port,
	output var logic [7:0]	w_in,
	// Answer
	input wire logic	w_load,
	input wire logic [7:0]	w_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle strobes
	initial
	begin
		{sel_lit_stb, sel_w_stb, sel_rd_stb, ctl_move_stb} = 4'h0;
		sel_lit = 4'h0;
		ctl_port = 3'h0;
		w_in = 8'h00;
	end
	// One instruction: 0 literal, 1 W to selector, 2 selector read, 3 move
	task automatic op(input logic [1:0] k, input logic [2:0] p, input logic [7:0] d,
		output logic ans, output logic [7:0] r);
		int i;
		@(posedge core_clk);
		sel_lit_stb <= (k == 2'h0);
		sel_w_stb <= (k == 2'h1);
		sel_rd_stb <= (k == 2'h2);
		ctl_move_stb <= (k == 2'h3);
		sel_lit <= d[3:0];
		ctl_port <= p;
		w_in <= d;
		@(posedge core_clk);
		{sel_lit_stb, sel_w_stb, sel_rd_stb, ctl_move_stb} <= 4'h0;
		// Released W shows the inverse, not the last value
		w_in <= ~d;
		ans = 1'b0;
		r = 8'h00;
		for (i = 0; i < 3 && !ans; i++)
		begin
			#1;
			if (w_load === 1'b1)
			begin
				ans = 1'b1;
				r = w_out;
			end
			else
				@(posedge core_clk);
		end
	endtask
endmodule // micaw_cpu_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the indexed control access unit.
// Assumes the CPU model and the bound checker are compiled first.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic		core_clk, resetn, ans, realtime_counter, rten, pdn;
	logic [7:0]	r, pin;
	logic [1:0]	ovf, cmpe, cape, saw_clr;
	logic [31:0]	cap;
	int		err_count, num_checks, k, p;
	wire logic	ls, ws, rs, ms, wl, irq;
	wire logic [3:0]	lit;
	wire logic [2:0]	prt;
	wire logic [7:0]	wi, wo, pend, cmpc;
	wire logic [39:0]	pdir, plvl, ppu, pst;
	wire logic [31:0]	c1, c2;
	wire logic [15:0]	ca, cb;
	wire logic [1:0]	clr;

	micaw_cpu_model cpu (.core_clk(core_clk), .sel_lit_stb(ls), .sel_lit(lit), .sel_w_stb(ws),
		.sel_rd_stb(rs), .ctl_move_stb(ms), .ctl_port(prt), .w_in(wi), .w_load(wl), .w_out(wo));
	micaw_ctrl_access dut (.core_clk(core_clk), .resetn(resetn), .sel_lit_stb(ls), .sel_lit(lit),
		.sel_w_stb(ws), .sel_rd_stb(rs), .ctl_move_stb(ms), .ctl_port(prt), .w_in(wi), .w_load(wl),
		.w_out(wo), .port_dir(pdir), .port_level_ttl(plvl), .port_pullup_off(ppu),
		.port_schmitt_off(pst), .comparator_control(cmpc), .tmr_capture(cap), .tmr_ovf_evt(ovf),
		.tmr_cmp_evt(cmpe), .tmr_cap_evt(cape), .tmr_compare1(c1), .tmr_compare2(c2),
		.tmr_control_a(ca), .tmr_control_b(cb), .tmr_clear(clr), .realtime_counter_rollover(realtime_counter),
		.realtime_counter_irq_en(rten), .wake_pin(pin), .power_down(pdn), .wakeup_pending(pend), .irq_req(irq));

	// Clock at 50 ns
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Sticky record of both timer clears
	always @(posedge core_clk)
		saw_clr <= saw_clr | clr;

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// Load selector from W
	task automatic sel(input logic [7:0] d);
		cpu.op(2'h1, 3'h0, d, ans, r);
	endtask
	// Port control move with expected answer
	task automatic mv(input logic [2:0] pp, input logic [7:0] d, input logic ea, input logic [7:0] ev);
		cpu.op(2'h3, pp, d, ans, r);
		chk({7'h0, ans}, {7'h0, ea});
		if (ea)
			chk(r, ev);
	endtask
	// Verdict
	task automatic close_out();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		close_out();
	end

	// Main sequence
	initial
	begin
		{resetn, realtime_counter, pdn, saw_clr, err_count, num_checks} = '0;
		{ovf, cmpe, cape, pin, rten} = '0;
		cap = 32'hbeef1234;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		rten <= 1'b1;
		repeat (3) @(posedge core_clk);
		// Selector reset value, literal keeps bit 4
		cpu.op(2'h2, 3'h0, 8'h00, ans, r);
		chk(r, 8'h1f);
		cpu.op(2'h0, 3'h0, 8'h03, ans, r);
		cpu.op(2'h2, 3'h0, 8'h00, ans, r);
		chk(r, 8'h13);
		sel(8'h0f);
		mv(3'h0, 8'h77, 1'b1, 8'hff);
		// Pullups of two ports under one selector
		sel(8'h1e);
		mv(3'h1, 8'h5a, 1'b0, 8'h00);
		mv(3'h2, 8'ha5, 1'b0, 8'h00);
		chk(ppu[15:8], 8'h5a);
		chk(ppu[23:16], 8'ha5);
		// Four config registers of port D
		for (k = 0; k < 4; k++)
		begin
			sel(8'h1c + k[7:0]);
			mv(3'h3, 8'h30 + k[7:0], 1'b0, 8'h00);
			sel(8'h0c + k[7:0]);
			mv(3'h3, 8'h00, 1'b1, 8'h30 + k[7:0]);
		end
		chk(pst[31:24], 8'h30);
		chk(plvl[31:24], 8'h31);
		chk(pdir[31:24], 8'h33);
		// No schmitt register on port A: write and read refused
		sel(8'h1c);
		mv(3'h0, 8'h00, 1'b0, 8'h00);
		chk(pst[7:0], 8'hff);
		sel(8'h0c);
		mv(3'h0, 8'h00, 1'b0, 8'h00);
		// Timer registers of both timers
		for (p = 1; p < 3; p++)
			for (k = 2; k < 8; k++)
			begin
				sel(8'h10 + k[7:0]);
				mv(p[2:0], {p[3:0], k[3:0]}, 1'b0, 8'h00);
				sel(k[7:0]);
				mv(p[2:0], 8'h00, 1'b1, {p[3:0], k[3:0]});
			end
		chk(c1[15:8], 8'h15);
		chk(c2[23:16], 8'h22);
		chk(ca[7:0], 8'h17);
		chk(cb[15:8], 8'h26);
		// Control B then A back to zero, no timer request left
		for (k = 6; k < 8; k++)
		begin
			sel(8'h10 + k[7:0]);
			mv(3'h1, 8'h00, 1'b0, 8'h00);
			mv(3'h2, 8'h00, 1'b0, 8'h00);
		end
		chk(ca[15:8], 8'h00);
		chk({7'h0, irq}, 8'h00);
		for (k = 0; k < 4; k++)
		begin
			sel({7'h0, k[0]});
			mv(3'h1 + {2'h0, k[1]}, 8'h00, 1'b1, cap[k*8 +: 8]);
		end
		// Clear pulses of timer 2 then timer 1
		sel(8'h10);
		mv(3'h2, 8'h00, 1'b0, 8'h00);
		chk({6'h0, saw_clr}, 8'h02);
		mv(3'h1, 8'h00, 1'b0, 8'h00);
		chk({6'h0, saw_clr}, 8'h03);
		// Reserved code does nothing
		sel(8'h11);
		mv(3'h1, 8'h00, 1'b0, 8'h00);
		// Rising edge on pin 0, pending cleared first
		sel(8'h0a);
		mv(3'h1, 8'h00, 1'b0, 8'h00);
		sel(8'h19);
		cpu.op(2'h3, 3'h1, 8'h00, ans, r);
		chk(pend, 8'h00);
		sel(8'h1b);
		mv(3'h1, 8'hfe, 1'b0, 8'h00);
		@(posedge core_clk);
		pin <= 8'h01;
		repeat (3) @(posedge core_clk);
		#1;
		chk(pend, 8'h01);
		chk({7'h0, irq}, 8'h01);
		@(posedge core_clk);
		pin <= 8'h00;
		sel(8'h09);
		mv(3'h1, 8'h00, 1'b1, 8'h01);
		repeat (2) @(posedge core_clk);
		#1;
		chk({7'h0, irq}, 8'h00);
		// Powered down: edge latched, no request
		@(posedge core_clk);
		pdn <= 1'b1;
		pin <= 8'h01;
		repeat (3) @(posedge core_clk);
		#1;
		chk(pend, 8'h01);
		chk({7'h0, irq}, 8'h00);
		// Comparator exchange
		sel(8'h18);
		mv(3'h1, 8'h3c, 1'b1, 8'h00);
		chk(cmpc, 8'h3c);
		// Rollover and one event of each timer source
		@(posedge core_clk);
		realtime_counter <= 1'b1;
		ovf <= 2'h2;
		cmpe <= 2'h1;
		cape <= 2'h2;
		@(posedge core_clk);
		realtime_counter <= 1'b0;
		{ovf, cmpe, cape} <= '0;
		repeat (2) @(posedge core_clk);
		#1;
		chk(cb[7:0], 8'h03);
		chk(cb[15:8], 8'h0c);
		chk({7'h0, irq}, 8'h01);
		close_out();
	end
endmodule // tb_top
`default_nettype wire
